// file: hw/duty_follow.sv
/*
 * Follow reference source: averages the duty of the tracking pulse train
 * over a fixed window, or passes a sampled analog level through.
 * Assumes the tracking pin is already synchronous to clk.
 */
`timescale 1ns/1ps

module duty_follow
    import pwm_refresh_pkg::*;
#(
    parameter int WINDOW_CLKS = 1000
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Tracking inputs
    input wire logic track_pin,
    input wire logic [11:0] track_analog_mv,
    input wire logic follow_source_select,
    // Result in millivolts
    output logic [11:0] follow_reference
);

    localparam int WW = $clog2(WINDOW_CLKS + 1);

    initial
    begin
        if (WINDOW_CLKS < 2 || WINDOW_CLKS > 65535)
            $error("duty_follow: WINDOW_CLKS out of range");
    end

    logic [WW-1:0] win_reg, win_next;
    logic [WW-1:0] high_reg, high_next;
    logic [11:0] ref_reg, ref_next;
    logic [31:0] scaled;

    // Amplitude does not matter: only the high count enters the average.
    always_comb
    begin
        win_next = win_reg + 1'b1;
        high_next = high_reg + WW'(track_pin);
        scaled = 32'(high_next) * 32'(TRACK_GAIN_MV) /
            32'(WINDOW_CLKS);
        ref_next = ref_reg;
        if (win_reg == WW'(WINDOW_CLKS - 1))
        begin
            win_next = '0;
            high_next = '0;
            ref_next = scaled[11:0];
        end
        if (follow_source_select)
            ref_next = track_analog_mv;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            win_reg <= '0;
            high_reg <= '0;
            ref_reg <= 12'h000;
        end
        else
        begin
            win_reg <= win_next;
            high_reg <= high_next;
            ref_reg <= ref_next;
        end
    end

    assign follow_reference = ref_reg;

endmodule : duty_follow

// file: hw/phase_pwm_boot_refresh_track.sv
/*
 * Per-phase PWM output stage with boot refresh bursts, undervoltage
 * response gating and regulation reference selection.
 * Assumes the loop supplies per-phase main switch timing and zero-current
 * cutoff requests, and a host writes the registers through the byte port.
 */
`timescale 1ns/1ps

module phase_pwm_boot_refresh_track
    import pwm_refresh_pkg::*;
#(
    parameter int PHASES = 4,
    parameter int CYCLE_CLKS = 60,
    parameter int REFRESH_INTERVAL = 256,
    parameter int TRACK_WINDOW_CLKS = 1000
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Register port
    input wire logic reg_wr,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    // Operating mode
    input wire logic pwm_tri_sel,
    input wire logic buck_mode,
    input wire logic zero_current_cutoff_mode,
    input wire logic startup_req,
    input wire logic pulse_skip,
    input wire logic [PHASES-1:0] phase_dropped,
    // Loop timing per phase
    input wire logic [PHASES-1:0] main_on,
    input wire logic [PHASES-1:0] zero_current_off,
    // PWM outputs: high level, or mid level when high is clear
    output logic [PHASES-1:0] pwm_high,
    output logic [PHASES-1:0] pwm_mid,
    // Reference sources in millivolts
    input wire logic track_pin,
    input wire logic [11:0] track_analog_mv,
    input wire logic [11:0] soft_start_mv,
    input wire logic [11:0] internal_ref_mv,
    output logic [11:0] regulation_ref_mv,
    // Undervoltage
    input wire logic uv_in_det,
    input wire logic uv_out_det,
    output logic uv_shutdown
);

    localparam int CW = $clog2(CYCLE_CLKS);
    localparam int IW = $clog2(REFRESH_INTERVAL + 1);

    initial
    begin
        if (PHASES < 2 || PHASES > 4)
            $error("phase count must be 2 to 4");
        if (CYCLE_CLKS % WIDTH_DIV_NARROW != 0 || CYCLE_CLKS % PHASES != 0)
            $error("cycle length must divide by 12 and phase count");
        if (REFRESH_INTERVAL < 2)
            $error("refresh interval too short");
    end

    // ***************************************************************
    // Registers
    // ***************************************************************
    logic [7:0] track_ctrl_reg, track_ctrl_next;
    logic [7:0] refresh_ctrl_reg, refresh_ctrl_next;
    logic [1:0] uv_flag_reg, uv_flag_next;
    logic [7:0] rdata_reg, rdata_next;
    logic [7:0] status;

    // A write of one clears a flag, but a detection in that cycle wins.
    always_comb
    begin
        track_ctrl_next = track_ctrl_reg;
        refresh_ctrl_next = refresh_ctrl_reg;
        uv_flag_next = uv_flag_reg;
        if (reg_wr && reg_addr == TRACK_CTRL_ADDR)
            track_ctrl_next = reg_wdata;
        if (reg_wr && reg_addr == REFRESH_CTRL_ADDR)
            refresh_ctrl_next = reg_wdata;
        if (reg_wr && reg_addr == STATUS_ADDR)
            uv_flag_next = uv_flag_reg & ~reg_wdata[1:0];
        uv_flag_next = uv_flag_next | {uv_out_det, uv_in_det};
        case (reg_addr)
            TRACK_CTRL_ADDR: rdata_next = track_ctrl_reg;
            REFRESH_CTRL_ADDR: rdata_next = refresh_ctrl_reg;
            STATUS_ADDR: rdata_next = status;
            default: rdata_next = 8'h00;
        endcase
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            track_ctrl_reg <= TRACK_CTRL_RESET;
            refresh_ctrl_reg <= REFRESH_CTRL_RESET;
            uv_flag_reg <= 2'h0;
            rdata_reg <= 8'h00;
        end
        else
        begin
            track_ctrl_reg <= track_ctrl_next;
            refresh_ctrl_reg <= refresh_ctrl_next;
            uv_flag_reg <= uv_flag_next;
            rdata_reg <= rdata_next;
        end
    end

    // ***************************************************************
    // Switching cycle and phase position
    // ***************************************************************
    logic [CW-1:0] cyc_reg, cyc_next;
    logic wrap;

    assign wrap = (cyc_reg == CW'(CYCLE_CLKS - 1));

    always_comb
    begin
        cyc_next = wrap ? '0 : cyc_reg + 1'b1;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            cyc_reg <= '0;
        else
            cyc_reg <= cyc_next;
    end

    // Position within the cycle as seen from a phase's own start point.
    function automatic logic [CW-1:0] phase_pos(
        input logic [CW-1:0] cyc,
        input int p
    );
        logic [CW-1:0] off;
        off = CW'(p * (CYCLE_CLKS / PHASES));
        if (cyc >= off)
            return cyc - off;
        return CW'(cyc + CW'(CYCLE_CLKS) - off);
    endfunction : phase_pos

    // ***************************************************************
    // Refresh sequencer
    // ***************************************************************
    refresh_state_e st_reg, st_next;
    logic [4:0] burst_cnt_reg, burst_cnt_next;
    logic [4:0] target_reg, target_next;
    logic [CW-1:0] width_reg, width_next;
    logic [PHASES-1:0] mask_reg, mask_next;
    logic start_pend_reg, start_pend_next;
    logic [IW-1:0] ivl_reg, ivl_next;
    logic ivl_done_reg, ivl_done_next;
    logic refresh_ok, light_load;

    assign refresh_ok = buck_mode && zero_current_cutoff_mode;
    assign light_load = pulse_skip || (|phase_dropped);

    always_comb
    begin
        st_next = st_reg;
        burst_cnt_next = burst_cnt_reg;
        target_next = target_reg;
        width_next = width_reg;
        mask_next = mask_reg;
        start_pend_next = start_pend_reg || startup_req;
        ivl_next = ivl_reg;
        ivl_done_next = ivl_done_reg;
        // Interval runs from the first drop while light load lasts.
        if (!light_load)
        begin
            ivl_next = '0;
            ivl_done_next = 1'b0;
        end
        else if (wrap && !ivl_done_reg)
        begin
            ivl_next = ivl_reg + 1'b1;
            if (ivl_reg == IW'(REFRESH_INTERVAL - 1))
            begin
                ivl_next = '0;
                ivl_done_next = 1'b1;
            end
        end
        case (st_reg)
            RF_IDLE:
            begin
                burst_cnt_next = '0;
                // Bursts begin on a cycle boundary so every masked phase gets
                // the full count at its normal offset.
                if (refresh_ok && wrap && start_pend_reg)
                begin
                    st_next = RF_START;
                    start_pend_next = startup_req;
                    mask_next = '1;
                    target_next = refresh_ctrl_reg[START_LONG_BIT] ?
                        START_PULSES_LONG : START_PULSES;
                    width_next = CW'(CYCLE_CLKS /
                        (refresh_ctrl_reg[START_WIDE_BIT] ?
                        WIDTH_DIV_WIDE : WIDTH_DIV_NARROW));
                end
                else if (refresh_ok && wrap && ivl_done_reg)
                begin
                    st_next = RF_PERIODIC;
                    ivl_done_next = 1'b0;
                    mask_next = pulse_skip ? '1 : phase_dropped;
                    target_next = refresh_ctrl_reg[DROP_LONG_BIT] ?
                        DROP_PULSES_LONG : DROP_PULSES;
                    width_next = CW'(CYCLE_CLKS /
                        (refresh_ctrl_reg[DROP_WIDE_BIT] ?
                        WIDTH_DIV_WIDE : WIDTH_DIV_NARROW));
                end
            end
            RF_START, RF_PERIODIC:
            begin
                if (wrap)
                begin
                    burst_cnt_next = burst_cnt_reg + 1'b1;
                    if (burst_cnt_reg == target_reg - 1'b1)
                        st_next = RF_IDLE;
                end
                if (!refresh_ok)
                    st_next = RF_IDLE;
            end
            default: st_next = RF_IDLE;
        endcase
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            st_reg <= RF_IDLE;
            burst_cnt_reg <= 5'h00;
            target_reg <= START_PULSES;
            width_reg <= '0;
            mask_reg <= '0;
            start_pend_reg <= 1'b0;
            ivl_reg <= '0;
            ivl_done_reg <= 1'b0;
        end
        else
        begin
            st_reg <= st_next;
            burst_cnt_reg <= burst_cnt_next;
            target_reg <= target_next;
            width_reg <= width_next;
            mask_reg <= mask_next;
            start_pend_reg <= start_pend_next;
            ivl_reg <= ivl_next;
            ivl_done_reg <= ivl_done_next;
        end
    end

    // ***************************************************************
    // PWM output levels
    // ***************************************************************
    logic [PHASES-1:0] refresh_low;
    logic [PHASES-1:0] high_next, mid_next;
    logic [PHASES-1:0] high_reg, mid_reg;

    always_comb
    begin
        for (int p = 0; p < PHASES; p++)
        begin
            refresh_low[p] = (st_reg != RF_IDLE) && mask_reg[p] &&
                (phase_pos(cyc_reg, p) < width_reg);
            if (!pwm_tri_sel)
            begin
                high_next[p] = main_on[p];
                mid_next[p] = 1'b0;
            end
            else if (refresh_low[p])
            begin
                high_next[p] = 1'b0;
                mid_next[p] = 1'b0;
            end
            else if (st_reg != RF_IDLE && mask_reg[p])
            begin
                high_next[p] = 1'b0;
                mid_next[p] = 1'b1;
            end
            else
            begin
                high_next[p] = main_on[p] && !phase_dropped[p];
                mid_next[p] = !high_next[p] &&
                    (zero_current_off[p] || phase_dropped[p]);
            end
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            high_reg <= '0;
            mid_reg <= '0;
        end
        else
        begin
            high_reg <= high_next;
            mid_reg <= mid_next;
        end
    end

    // ***************************************************************
    // Reference and undervoltage response
    // ***************************************************************
    logic [11:0] follow_ref;
    logic [11:0] ref_reg, ref_next;
    logic uv_stop_reg, uv_stop_next;

    // Runs from reset onward, so it steers the reference during soft-start.
    duty_follow #(
        .WINDOW_CLKS(TRACK_WINDOW_CLKS)
    ) follow_u (
        .clk(clk),
        .rst(rst),
        .track_pin(track_pin),
        .track_analog_mv(track_analog_mv),
        .follow_source_select(track_ctrl_reg[FOLLOW_SRC_BIT]),
        .follow_reference(follow_ref)
    );

    always_comb
    begin
        ref_next = min3(soft_start_mv, internal_ref_mv, follow_ref);
        uv_stop_next = (uv_in_det && !track_ctrl_reg[UV_IN_OVR_BIT]) ||
            (uv_out_det && !track_ctrl_reg[UV_OUT_OVR_BIT]);
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            ref_reg <= 12'h000;
            uv_stop_reg <= 1'b0;
        end
        else
        begin
            ref_reg <= ref_next;
            uv_stop_reg <= uv_stop_next;
        end
    end

    assign status = {3'h0, track_ctrl_reg[FOLLOW_SRC_BIT],
        st_reg == RF_PERIODIC, st_reg == RF_START, uv_flag_reg};
    assign pwm_high = high_reg;
    assign pwm_mid = mid_reg;
    assign regulation_ref_mv = ref_reg;
    assign uv_shutdown = uv_stop_reg;
    assign reg_rdata = rdata_reg;

    // ***************************************************************
    // Checks
    // ***************************************************************
    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    two_level_a: assert property (!pwm_tri_sel |=> pwm_mid == '0)
        else $error("mid level seen in two-level mode");
    main_follow_a: assert property (!pwm_tri_sel |=> pwm_high == $past(main_on))
        else $error("two-level output does not follow main timing");
    refresh_gate_a: assert property (st_reg == RF_IDLE && !refresh_ok |=> st_reg == RF_IDLE)
        else $error("refresh started outside buck cutoff mode");
    burst_count_a: assert property (st_reg != RF_IDLE |-> burst_cnt_reg < target_reg)
        else $error("refresh burst overran its count");
    refresh_low_a: assert property (refresh_low[0] && pwm_tri_sel |=> !pwm_high[0] && !pwm_mid[0])
        else $error("refresh pulse not driven low");
    phase_offset_a: assert property (refresh_low[1] |-> cyc_reg >= CW'(CYCLE_CLKS / PHASES))
        else $error("refresh pulse lost phase offset");
    start_target_a: assert property ($rose(st_reg == RF_START) |-> target_reg == START_PULSES || target_reg == START_PULSES_LONG)
        else $error("start-up burst count wrong");
    interval_a: assert property ($rose(st_reg == RF_PERIODIC) |-> $past(ivl_done_reg) && $past(wrap))
        else $error("periodic burst without interval expiry");
    skip_all_a: assert property ($rose(st_reg == RF_PERIODIC) && $past(pulse_skip) |-> mask_reg == '1)
        else $error("pulse skipping burst missed phases");
    ref_min_a: assert property (1'b1 |=> regulation_ref_mv <= $past(soft_start_mv) && regulation_ref_mv <= $past(internal_ref_mv))
        else $error("reference above a source");
    uv_flag_a: assert property (uv_in_det |=> status[UV_IN_FLAG_BIT] ##1 1'b1)
        else $error("undervoltage flag not set");
    uv_hold_a: assert property (uv_out_det && !uv_in_det && track_ctrl_reg[UV_OUT_OVR_BIT] |=> !uv_shutdown)
        else $error("overridden undervoltage caused shutdown");

endmodule : phase_pwm_boot_refresh_track

// file: hw/pwm_refresh_pkg.sv
/*
 * Constants shared by the per-phase PWM output, boot refresh and tracking
 * reference logic: register addresses, field positions, reset values,
 * refresh counts and the refresh sequencer states.
 * Assumes a host that reaches the registers through a byte-wide
 * register port that sits behind the management bus.
 */
// Behaviour
// - Select pin low gives two-level outputs only
// - Two-level output follows main switch timing
// - Refresh only in buck with zero-current cutoff
// - Start-up default: eight pulses, twelfth-cycle wide
// - Register selects sixth-cycle width, sixteen pulses
// - Refresh pulses keep normal interphase offset
// - First drop starts interval; expiry refreshes dropped
// - Drop refresh: four or eight pulses, width selectable
// - Pulse skipping refreshes all phases, same settings
// - Control bit four selects analog follow source
// - Digital follow reference is 2.5 times duty
// - Follow reference active before soft-start
// - Reference is minimum of three sources
// - Overridden undervoltage only sets a flag
package pwm_refresh_pkg;

    // ***************************************************************
    // Register map
    // ***************************************************************
    localparam logic [7:0] TRACK_CTRL_ADDR = 8'hB0;
    localparam logic [7:0] REFRESH_CTRL_ADDR = 8'hEC;
    localparam logic [7:0] STATUS_ADDR = 8'hED;
    localparam logic [7:0] TRACK_CTRL_RESET = 8'h00;
    localparam logic [7:0] REFRESH_CTRL_RESET = 8'h00;

    // Fields of the tracking and mode control register.
    localparam int UV_IN_OVR_BIT = 0;
    localparam int UV_OUT_OVR_BIT = 1;
    localparam int FOLLOW_SRC_BIT = 4;

    // Fields of the boot refresh control register.
    localparam int START_WIDE_BIT = 0;
    localparam int START_LONG_BIT = 1;
    localparam int DROP_WIDE_BIT = 2;
    localparam int DROP_LONG_BIT = 3;

    // Fields of the status register.
    localparam int UV_IN_FLAG_BIT = 0;
    localparam int UV_OUT_FLAG_BIT = 1;
    localparam int START_BUSY_BIT = 2;
    localparam int DROP_BUSY_BIT = 3;
    localparam int FOLLOW_SRC_STAT_BIT = 4;

    // ***************************************************************
    // Refresh burst figures
    // ***************************************************************
    localparam logic [4:0] START_PULSES = 5'h08;
    localparam logic [4:0] START_PULSES_LONG = 5'h10;
    localparam logic [4:0] DROP_PULSES = 5'h04;
    localparam logic [4:0] DROP_PULSES_LONG = 5'h08;
    localparam int WIDTH_DIV_NARROW = 12;
    localparam int WIDTH_DIV_WIDE = 6;

    // Follow reference gain in millivolts per full duty.
    localparam int TRACK_GAIN_MV = 2500;

    typedef enum logic [1:0] {
        RF_IDLE,
        RF_START,
        RF_PERIODIC
    } refresh_state_e;

    function automatic logic [11:0] min3(
        input logic [11:0] a,
        input logic [11:0] b,
        input logic [11:0] c
    );
        logic [11:0] m;
        m = (a < b) ? a : b;
        return (m < c) ? m : c;
    endfunction : min3

endpackage : pwm_refresh_pkg

// file: verif/fet_driver_model.sv
/*
 * Stand-in for the external gate drivers: decodes the per-phase PWM
 * levels into gate enables and measures each refresh burst.
 * Assumes the PWM outputs change only after the rising clock edge.
 */
`timescale 1ns/1ps

module fet_driver_model #(
    parameter int PHASES = 4,
    parameter int GAP = 120
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // PWM levels from the controller
    input wire logic [PHASES-1:0] pwm_high,
    input wire logic [PHASES-1:0] pwm_mid,
    input wire logic sync_off,
    // Gate enables
    output logic [PHASES-1:0] high_fet_on,
    output logic [PHASES-1:0] low_fet_on,
    // Burst measurements
    output int burst_pulses [PHASES],
    output int pulse_width [PHASES],
    output int burst_start [PHASES],
    output int now,
    output logic quiet
);
    int idle [PHASES];
    logic [PHASES-1:0] low_prev;
    logic [PHASES-1:0] low_lvl;

    assign low_lvl = ~pwm_high & ~pwm_mid;
    assign high_fet_on = pwm_high;
    // A two-level driver cannot idle both FETs, so the system holds the
    // synchronous FET off instead.
    assign low_fet_on = low_lvl & {PHASES{~sync_off}};

    // A low after a long idle opens a new burst.
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            now <= 0;
            low_prev <= '1;
            quiet <= 1'b1;
            for (int p = 0; p < PHASES; p++)
            begin
                idle[p] <= GAP;
                burst_pulses[p] <= 0;
                pulse_width[p] <= 0;
                burst_start[p] <= 0;
            end
        end
        else
        begin
            now <= now + 1;
            low_prev <= low_lvl;
            quiet <= 1'b1;
            for (int p = 0; p < PHASES; p++)
            begin
                idle[p] <= low_lvl[p] ? 0 : idle[p] + 1;
                if (idle[p] < GAP)
                    quiet <= 1'b0;
                if (low_lvl[p] && !low_prev[p])
                begin
                    burst_pulses[p] <= (idle[p] >= GAP) ? 1
                                       : burst_pulses[p] + 1;
                    if (idle[p] >= GAP)
                        burst_start[p] <= now;
                    pulse_width[p] <= 1;
                end
                else if (low_lvl[p])
                    pulse_width[p] <= pulse_width[p] + 1;
            end
        end
    end
endmodule : fet_driver_model

// file: verif/tb.sv
/*
 * Self-checking bench for the PWM output, boot refresh and reference
 * selection block, driven through its byte-wide register port.
 * Assumes the driver model in fet_driver_model.sv.
 */
`timescale 1ns/1ps

`define CHK(nm, got, exp) \
    begin \
        n_checks++; \
        if ((got) !== (exp)) \
        begin \
            failures++; \
            $display("[ERR] %s expected %0h seen %0h", nm, exp, got); \
        end \
    end

module tb;
    import pwm_refresh_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic reg_wr = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] reg_rdata;
    logic pwm_tri_sel = 1'b1;
    logic buck_mode = 1'b1;
    logic zero_current_cutoff_mode = 1'b1;
    logic startup_req = 1'b0;
    logic pulse_skip = 1'b0;
    logic [3:0] phase_dropped = 4'h0;
    logic [3:0] main_on = 4'h0;
    logic [3:0] zero_current_off = 4'hF;
    logic [3:0] pwm_high;
    logic [3:0] pwm_mid;
    logic track_pin = 1'b0;
    logic [11:0] track_analog_mv = 12'h300;
    logic [11:0] soft_start_mv = 12'hFFF;
    logic [11:0] internal_ref_mv = 12'hFFF;
    logic [11:0] regulation_ref_mv;
    logic uv_out_det = 1'b0;
    logic uv_in_det = 1'b0;
    logic uv_shutdown;
    logic [3:0] prev;
    logic [7:0] d;
    int burst_pulses [4];
    int pulse_width [4];
    int burst_start [4];
    int now;
    int t;
    logic quiet;
    int failures = 0;
    int n_checks = 0;

    always #20 clk = ~clk;
    always @(negedge clk) track_pin <= ~track_pin;

    phase_pwm_boot_refresh_track #(.PHASES(4), .CYCLE_CLKS(60),
        .REFRESH_INTERVAL(16), .TRACK_WINDOW_CLKS(20))
    i_phase_pwm_boot_refresh_track (.clk(clk), .rst(rst), .reg_wr(reg_wr),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .pwm_tri_sel(pwm_tri_sel), .buck_mode(buck_mode),
        .zero_current_cutoff_mode(zero_current_cutoff_mode),
        .startup_req(startup_req), .pulse_skip(pulse_skip),
        .phase_dropped(phase_dropped), .main_on(main_on),
        .zero_current_off(zero_current_off), .pwm_high(pwm_high),
        .pwm_mid(pwm_mid), .track_pin(track_pin),
        .track_analog_mv(track_analog_mv), .soft_start_mv(soft_start_mv),
        .internal_ref_mv(internal_ref_mv),
        .regulation_ref_mv(regulation_ref_mv), .uv_in_det(uv_in_det),
        .uv_out_det(uv_out_det), .uv_shutdown(uv_shutdown));

    fet_driver_model #(.PHASES(4), .GAP(120)) i_fet_driver_model (
        .clk(clk), .rst(rst), .pwm_high(pwm_high), .pwm_mid(pwm_mid),
        .sync_off(~pwm_tri_sel), .high_fet_on(), .low_fet_on(),
        .burst_pulses(burst_pulses), .pulse_width(pulse_width),
        .burst_start(burst_start), .now(now), .quiet(quiet));

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(negedge clk);
        reg_addr = a;
        reg_wdata = v;
        reg_wr = 1'b1;
        @(negedge clk);
        reg_wr = 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(negedge clk);
        reg_addr = a;
        @(negedge clk);
        v = reg_rdata;
    endtask : rd

    task automatic kick;
        @(negedge clk);
        startup_req = 1'b1;
        @(negedge clk);
        startup_req = 1'b0;
    endtask : kick

    task automatic wait_q(input logic v);
        int k;
        k = 0;
        while (quiet !== v && k < 3000)
        begin
            @(negedge clk);
            k++;
        end
        `CHK("quiet", quiet, v)
    endtask : wait_q

    task automatic burst(input int n, input int w, input logic [3:0] m);
        int t0;
        t0 = now;
        wait_q(1'b0);
        wait_q(1'b1);
        for (int p = 0; p < 4; p++)
        begin
            if (m[p])
            begin
                `CHK("pulses", burst_pulses[p], n)
                `CHK("width", pulse_width[p], w)
            end
            else
                `CHK("idle phase", burst_start[p] < t0, 1'b1)
        end
    endtask : burst

    task automatic print_verdict;
        $display("checks %0d errors %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : print_verdict

    initial
    begin
        repeat (40000) @(posedge clk);
        failures++;
        print_verdict();
    end

    // ***************************************************************
    // Main sequence
    // ***************************************************************
    initial
    begin
        repeat (10) @(negedge clk);
        rst = 1'b0;
        repeat (200) @(negedge clk);
        rd(TRACK_CTRL_ADDR, d);
        `CHK("track ctrl reset", d, 8'h00)
        rd(REFRESH_CTRL_ADDR, d);
        `CHK("refresh ctrl reset", d, 8'h00)
        wr(8'h40, 8'h55);
        rd(8'h40, d);
        `CHK("unmapped", d, 8'h00)
        kick();
        burst(8, 5, 4'hF);
        for (int p = 1; p < 4; p++)
            `CHK("offset", burst_start[p] - burst_start[0], p * 15)
        wr(REFRESH_CTRL_ADDR, 8'h03);
        rd(REFRESH_CTRL_ADDR, d);
        `CHK("refresh ctrl", d, 8'h03)
        buck_mode = 1'b0;
        kick();
        t = now;
        repeat (750) @(negedge clk);
        buck_mode = 1'b1;
        zero_current_cutoff_mode = 1'b0;
        repeat (750) @(negedge clk);
        `CHK("no refresh", burst_start[0] < t, 1'b1)
        zero_current_cutoff_mode = 1'b1;
        burst(16, 10, 4'hF);
        wr(REFRESH_CTRL_ADDR, 8'h00);
        phase_dropped = 4'h4;
        burst(4, 5, 4'h4);
        wr(REFRESH_CTRL_ADDR, 8'h0C);
        burst(8, 10, 4'h4);
        phase_dropped = 4'h0;
        pulse_skip = 1'b1;
        burst(8, 10, 4'hF);
        pulse_skip = 1'b0;
        pwm_tri_sel = 1'b0;
        prev = main_on;
        kick();
        for (int i = 0; i < 64; i++)
        begin
            @(negedge clk);
            `CHK("two-level high", pwm_high, prev)
            `CHK("two-level mid", pwm_mid, 4'h0)
            main_on = i[3:0];
            prev = main_on;
        end
        wr(TRACK_CTRL_ADDR, 8'h10);
        internal_ref_mv = 12'h640;
        repeat (4) @(negedge clk);
        `CHK("analog follow", regulation_ref_mv, 12'h300)
        soft_start_mv = 12'h200;
        repeat (4) @(negedge clk);
        `CHK("soft-start min", regulation_ref_mv, 12'h200)
        track_analog_mv = 12'h180;
        repeat (4) @(negedge clk);
        `CHK("analog follow low", regulation_ref_mv, 12'h180)
        soft_start_mv = 12'hFFF;
        wr(TRACK_CTRL_ADDR, 8'h00);
        repeat (70) @(negedge clk);
        `CHK("digital follow", regulation_ref_mv, 12'h4E2)
        wr(TRACK_CTRL_ADDR, 8'h02);
        uv_out_det = 1'b1;
        repeat (4) @(negedge clk);
        `CHK("uv overridden", uv_shutdown, 1'b0)
        rd(STATUS_ADDR, d);
        `CHK("uv flag", d[UV_OUT_FLAG_BIT], 1'b1)
        wr(TRACK_CTRL_ADDR, 8'h00);
        repeat (4) @(negedge clk);
        `CHK("uv shutdown", uv_shutdown, 1'b1)
        uv_in_det = 1'b1;
        repeat (2) @(negedge clk);
        rd(STATUS_ADDR, d);
        `CHK("uv in flag", d[UV_IN_FLAG_BIT], 1'b1)
        print_verdict();
    end
endmodule : tb
